// ---- src/post_reset_pkg.sv ----
package post_reset_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned RESET_SEQ_CYCLES = 516;
  localparam logic [9:0] RESET_SEQ_LAST = 10'h0203;
  localparam logic [15:0] DATA_PAGE_PTR_1_RST = 16'h0001;
  localparam logic [15:0] DATA_PAGE_PTR_2_RST = 16'h0002;
  localparam logic [15:0] DATA_PAGE_PTR_3_RST = 16'h0003;
  localparam logic [15:0] STACK_RST = 16'hFC00;
  localparam logic [15:0] STACK_OVERFLOW_LIMIT_RST = 16'hFA00;
  localparam logic [15:0] WDCON_WD_RST = 16'h0002;
  localparam logic [15:0] WDCON_OTHER_RST = 16'h0000;
  localparam logic [7:0] WD_RELOAD_RST = 8'h00;
  localparam int unsigned WDCON_CAUSE_BIT = 1;
  localparam int unsigned WDCON_PRESCALE_BIT = 0;
  localparam int unsigned BUSCON_TYPE_LSB = 6;
  localparam int unsigned BUSCON_LATCH_BIT = 9;
  localparam int unsigned BUSCON_ACTIVE_BIT = 10;
  localparam int unsigned SYSTEM_CONFIG_REG_HIGH_BYTE_ENABLE_DISABLE_BIT = 9;
  localparam int unsigned SYSTEM_CONFIG_REG_INTERNAL_ROM_ENABLE_BIT = 10;
  localparam int unsigned CFG_TYPE_LSB = 6;
  localparam int unsigned CFG_WIDTH_BIT = 7;
  localparam logic [1:0] BUS_TYPE_NONE = 2'h0;

  typedef struct packed {
    logic end_of_init;
    logic wd_service;
    logic wd_disable;
    logic sw_reset;
  } instr_strobes_t;

  typedef struct packed {
    logic [15:0] data_page_ptr_1;
    logic [15:0] data_page_ptr_2;
    logic [15:0] data_page_ptr_3;
    logic [15:0] context_pointer;
    logic [15:0] stack_pointer;
    logic [15:0] stack_underflow_limit;
    logic [15:0] stack_overflow_limit;
    logic [15:0] watchdog_control_reg;
    logic [15:0] system_config_reg;
    logic [15:0] bus_config_reg_0;
  } reset_regs_t;

  typedef enum logic [2:0] {
    ST_SEQ = 3'b001,
    ST_HOLD = 3'b010,
    ST_RUN = 3'b100
  } seq_state_t;
endpackage : post_reset_pkg

// ---- src/reset_input_sync.sv ----
`timescale 1ns/10ps
module reset_input_sync (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_hw_reset_in_n,
  output logic o_hw_reset_in_n
);
  logic meta_ff;
  logic sync_ff;

  // two stages before the sequence logic reads the pin; the reset output reads it raw
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else if (i_ce) begin
      meta_ff <= i_hw_reset_in_n;
      sync_ff <= meta_ff;
    end
  end

  assign o_hw_reset_in_n = sync_ff;
endmodule : reset_input_sync

// ---- src/watchdog_counter.sv ----
`timescale 1ns/10ps
module watchdog_counter #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_clear,
  input wire logic i_run,
  input wire logic i_service,
  input wire logic i_prescale_128,
  input wire logic [7:0] i_reload,
  output logic o_overflow
);
  logic [WIDTH-1:0] count_ff;
  logic [6:0] pre_ff;
  logic tick;
  logic ovf_ff;

  assign tick = i_prescale_128 ? (pre_ff == 7'h7F) : pre_ff[0];

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pre_ff <= 7'h00;
    end else if (i_ce) begin
      if (i_clear || i_service || !i_run) begin
        pre_ff <= 7'h00;
      end else begin
        pre_ff <= pre_ff + 7'h01;
      end
    end
  end

  // counts up; service clears low byte and reloads high byte
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_ff <= '0;
    end else if (i_ce) begin
      if (i_clear) begin
        count_ff <= '0;
      end else if (i_service) begin
        count_ff <= {i_reload, {(WIDTH-8){1'b0}}};
      end else if (i_run && tick) begin
        count_ff <= count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ovf_ff <= 1'b0;
    end else if (i_ce) begin
      ovf_ff <= i_run && tick && !i_service && !i_clear && (&count_ff);
    end
  end

  assign o_overflow = ovf_ff;
endmodule : watchdog_counter

// ---- src/post_reset_state_control.sv ----
`timescale 1ns/10ps
module post_reset_state_control #(
  parameter int unsigned NUM_GPIO = 16,
  parameter int unsigned NUM_CS = 5,
  parameter int unsigned NUM_SEG = 8
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_hw_reset_in_n,
  input wire logic [15:0] i_startup_config_port,
  input wire post_reset_pkg::instr_strobes_t i_instr,
  input wire logic i_wdcon_we,
  input wire logic [15:0] i_wdcon_wdata,
  input wire logic [NUM_GPIO-1:0] i_gpio_dir_wdata,
  input wire logic i_gpio_dir_we,
  output logic o_system_reset_out_n,
  output logic o_internal_reset,
  output logic o_bus_active,
  output logic o_latch_strobe_weak_low,
  output logic o_rdwr_cs_weak_high,
  output logic o_ready_enable,
  output logic [NUM_SEG-1:0] o_segment_lines,
  output logic [NUM_CS-1:0] o_chip_select_n,
  output logic [NUM_GPIO-1:0] o_gpio_oe,
  output logic [7:0] o_startup_config_latch,
  output logic o_watchdog_cause_flag,
  output logic o_watchdog_enabled,
  output logic o_disable_allowed,
  output post_reset_pkg::reset_regs_t o_regs
);
  logic hw_in_n;
  logic seq_start;
  logic wd_ovf;
  logic [9:0] seq_cnt_ff;
  post_reset_pkg::seq_state_t state_ff;
  post_reset_pkg::seq_state_t nxt_state;
  logic run;
  logic rst_out_ff;
  logic wd_reset_ff;
  logic hw_reset_ff;
  logic wd_en_ff;
  logic dis_ok_ff;
  logic [15:0] wdcon_ff;
  logic [7:0] cfg_low_ff;
  logic [7:0] cfg_high_ff;
  logic [NUM_GPIO-1:0] gpio_dir_ff;
  logic bus_external;

  reset_input_sync u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_hw_reset_in_n(i_hw_reset_in_n),
    .o_hw_reset_in_n(hw_in_n)
  );

  // any reset source starts the sequence
  assign seq_start = !hw_in_n || i_instr.sw_reset || wd_ovf;
  assign run = (state_ff == post_reset_pkg::ST_RUN);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      post_reset_pkg::ST_SEQ: begin
        if (seq_cnt_ff == post_reset_pkg::RESET_SEQ_LAST) begin
          nxt_state = hw_in_n ? post_reset_pkg::ST_RUN : post_reset_pkg::ST_HOLD;
        end
      end
      post_reset_pkg::ST_HOLD: begin
        if (hw_in_n) begin
          nxt_state = post_reset_pkg::ST_RUN;
        end
      end
      post_reset_pkg::ST_RUN: begin
        nxt_state = post_reset_pkg::ST_RUN;
      end
      default: begin
        nxt_state = post_reset_pkg::ST_SEQ;
      end
    endcase
    if (seq_start && state_ff == post_reset_pkg::ST_RUN) begin
      nxt_state = post_reset_pkg::ST_SEQ;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= post_reset_pkg::ST_SEQ;
      seq_cnt_ff <= 10'h0000;
    end else if (i_ce) begin
      state_ff <= nxt_state;
      if (nxt_state == post_reset_pkg::ST_SEQ && state_ff != post_reset_pkg::ST_SEQ) begin
        seq_cnt_ff <= 10'h0000;
      end else if (state_ff == post_reset_pkg::ST_SEQ) begin
        seq_cnt_ff <= seq_cnt_ff + 10'h0001;
      end
    end
  end

  // remembers the cause of the latest sequence
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wd_reset_ff <= 1'b0;
      hw_reset_ff <= 1'b1;
    end else if (i_ce && run && seq_start) begin
      wd_reset_ff <= wd_ovf && hw_in_n;
      hw_reset_ff <= !hw_in_n;
    end else if (i_ce && !run && !hw_in_n) begin
      wd_reset_ff <= 1'b0;
      hw_reset_ff <= 1'b1;
    end
  end

  // async low on the pin reset, sync low on software or watchdog
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_out_ff <= 1'b0;
    end else if (i_ce) begin
      if (seq_start) begin
        rst_out_ff <= 1'b0;
      end else if (run && i_instr.end_of_init) begin
        rst_out_ff <= 1'b1;
      end
    end
  end
  assign o_system_reset_out_n = rst_out_ff && i_hw_reset_in_n;

  // startup configuration sampled during the sequence
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_low_ff <= 8'h00;
      cfg_high_ff <= 8'h00;
    end else if (i_ce && !run) begin
      cfg_low_ff <= i_startup_config_port[7:0];
      cfg_high_ff <= i_startup_config_port[15:8];
    end
  end

  assign bus_external = (cfg_low_ff[post_reset_pkg::CFG_TYPE_LSB +: 2] != post_reset_pkg::BUS_TYPE_NONE);

  // watchdog control register and its cause flag
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wdcon_ff <= post_reset_pkg::WDCON_OTHER_RST;
    end else if (i_ce) begin
      if (!run) begin
        wdcon_ff <= wd_reset_ff ? post_reset_pkg::WDCON_WD_RST : post_reset_pkg::WDCON_OTHER_RST;
        if (hw_reset_ff) begin
          wdcon_ff <= post_reset_pkg::WDCON_OTHER_RST;
        end
      end else if (i_instr.wd_service) begin
        wdcon_ff[post_reset_pkg::WDCON_CAUSE_BIT] <= 1'b0;
      end else if (i_wdcon_we) begin
        wdcon_ff[15:8] <= i_wdcon_wdata[15:8];
        wdcon_ff[post_reset_pkg::WDCON_PRESCALE_BIT] <= i_wdcon_wdata[post_reset_pkg::WDCON_PRESCALE_BIT];
      end
    end
  end

  // disable window closes on first service or end-of-init
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wd_en_ff <= 1'b1;
      dis_ok_ff <= 1'b1;
    end else if (i_ce) begin
      if (!run) begin
        wd_en_ff <= 1'b1;
        dis_ok_ff <= 1'b1;
      end else begin
        if (i_instr.wd_disable && dis_ok_ff) begin
          wd_en_ff <= 1'b0;
        end
        if (i_instr.wd_service || i_instr.end_of_init) begin
          dis_ok_ff <= 1'b0;
        end
      end
    end
  end

  watchdog_counter #(
    .WIDTH(16)
  ) u_wdt (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_clear(!run),
    .i_run(run && wd_en_ff),
    .i_service(i_instr.wd_service),
    .i_prescale_128(wdcon_ff[post_reset_pkg::WDCON_PRESCALE_BIT]),
    .i_reload(wdcon_ff[15:8]),
    .o_overflow(wd_ovf)
  );

  // direction registers cleared by every reset; ram is not touched here
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gpio_dir_ff <= '0;
    end else if (i_ce) begin
      if (!run) begin
        gpio_dir_ff <= '0;
      end else if (i_gpio_dir_we) begin
        gpio_dir_ff <= i_gpio_dir_wdata;
      end
    end
  end
  assign o_gpio_oe = gpio_dir_ff;

  always_comb begin
    o_regs = '0;
    o_regs.data_page_ptr_1 = post_reset_pkg::DATA_PAGE_PTR_1_RST;
    o_regs.data_page_ptr_2 = post_reset_pkg::DATA_PAGE_PTR_2_RST;
    o_regs.data_page_ptr_3 = post_reset_pkg::DATA_PAGE_PTR_3_RST;
    o_regs.context_pointer = post_reset_pkg::STACK_RST;
    o_regs.stack_pointer = post_reset_pkg::STACK_RST;
    o_regs.stack_underflow_limit = post_reset_pkg::STACK_RST;
    o_regs.stack_overflow_limit = post_reset_pkg::STACK_OVERFLOW_LIMIT_RST;
    o_regs.watchdog_control_reg = wdcon_ff;
    o_regs.system_config_reg[post_reset_pkg::SYSTEM_CONFIG_REG_INTERNAL_ROM_ENABLE_BIT] = 1'b0;
    o_regs.system_config_reg[post_reset_pkg::SYSTEM_CONFIG_REG_HIGH_BYTE_ENABLE_DISABLE_BIT] = !cfg_low_ff[post_reset_pkg::CFG_WIDTH_BIT];
    o_regs.bus_config_reg_0[post_reset_pkg::BUSCON_TYPE_LSB +: 2] =
      cfg_low_ff[post_reset_pkg::CFG_TYPE_LSB +: 2];
    o_regs.bus_config_reg_0[post_reset_pkg::BUSCON_ACTIVE_BIT] = 1'b1;
    o_regs.bus_config_reg_0[post_reset_pkg::BUSCON_LATCH_BIT] = 1'b1;
  end

  // pins activate only once the internal reset condition has ended
  assign o_internal_reset = !run;
  assign o_bus_active = run && bus_external;
  assign o_latch_strobe_weak_low = !run;
  assign o_rdwr_cs_weak_high = !run;
  assign o_ready_enable = 1'b0;
  assign o_segment_lines = '0;

  genvar g;
  generate
    for (g = 0; g < NUM_CS; g++) begin : gen_cs
      if (g == 0) begin : gen_first
        assign o_chip_select_n[g] = !(run && bus_external);
      end else begin : gen_other
        assign o_chip_select_n[g] = 1'b1;
      end
    end
  endgenerate

  assign o_startup_config_latch = cfg_high_ff;
  assign o_watchdog_cause_flag = wdcon_ff[post_reset_pkg::WDCON_CAUSE_BIT];
  assign o_watchdog_enabled = wd_en_ff;
  assign o_disable_allowed = dis_ok_ff;

  chk_seq_length: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && state_ff == post_reset_pkg::ST_SEQ && seq_cnt_ff == 10'h0000) |-> !run [*8])
    else $error("reset sequence ended too early");
  chk_out_low_seq: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !run |-> !o_system_reset_out_n)
    else $error("reset output high during sequence");
  chk_out_until_init: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && run && i_instr.end_of_init && !seq_start && i_hw_reset_in_n && hw_in_n) |=> o_system_reset_out_n)
    else $error("reset output not released by end of init");
  chk_disable_window: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (run && !dis_ok_ff && wd_en_ff && !seq_start) |=> wd_en_ff)
    else $error("watchdog disabled outside window");
  chk_cause_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && run && i_instr.wd_service) |=> !o_watchdog_cause_flag)
    else $error("cause flag not cleared by service");
  chk_gpio_input: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ($fell(run)) |=> (o_gpio_oe == '0))
    else $error("port direction not cleared by reset");
  chk_bus_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_ff == post_reset_pkg::ST_HOLD) |-> (!o_bus_active && o_chip_select_n[0]))
    else $error("outputs active during extended reset");
  chk_stack_preset: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(run) |-> (o_regs.stack_pointer == post_reset_pkg::STACK_RST &&
      o_regs.bus_config_reg_0[post_reset_pkg::BUSCON_ACTIVE_BIT]))
    else $error("stack or bus config preset wrong");

  // sequence entry and exit, cause tracking and frozen state while running
  chk_reset_entry: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && run && seq_start) |=> (!run && !rst_out_ff))
    else $error("reset source did not start the sequence");
  chk_seq_end: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && state_ff == post_reset_pkg::ST_SEQ && seq_cnt_ff == post_reset_pkg::RESET_SEQ_LAST &&
      hw_in_n) |=> run)
    else $error("sequence did not end after its last count");
  chk_hold_extend: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && state_ff == post_reset_pkg::ST_HOLD && !hw_in_n) |=> !run)
    else $error("extended reset ended while pin low");
  chk_cause_set: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && run && wd_ovf && hw_in_n) |-> ##2 o_watchdog_cause_flag)
    else $error("watchdog reset did not set cause flag");
  chk_pin_cause: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && !run && !hw_in_n) |-> ##2 !o_watchdog_cause_flag)
    else $error("pin reset did not clear cause flag");
  chk_wdcon_kind: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(run) |-> (wdcon_ff == post_reset_pkg::WDCON_WD_RST || wdcon_ff == post_reset_pkg::WDCON_OTHER_RST))
    else $error("watchdog control preset wrong");
  chk_wd_restart: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(run) |-> (wd_en_ff && dis_ok_ff))
    else $error("watchdog not running after reset");
  chk_gpio_stable: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && run && !i_gpio_dir_we) |=> $stable(o_gpio_oe))
    else $error("port direction changed without a write");
  chk_cfg_frozen: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && run) |=> $stable(o_startup_config_latch))
    else $error("startup configuration changed while running");
endmodule : post_reset_state_control

// ---- tb/reset_partner.sv ----
`timescale 1ns/10ps
module reset_partner (
  input wire logic i_clk,
  input wire logic i_system_reset_out_n,
  output logic o_hw_reset_in_n,
  output logic [15:0] o_startup_config_port,
  output logic o_external_access_pin
);
  logic periph_in_reset_ff;
  // the board ties the external access pin low
  assign o_external_access_pin = 1'b0;
  initial begin
    o_hw_reset_in_n = 1'b1;
    o_startup_config_port = 16'hFFFF;
  end
  // system peripherals stay in reset while the reset output is low
  always @(posedge i_clk) begin
    periph_in_reset_ff <= ~i_system_reset_out_n;
  end
  task automatic set_config(input logic [15:0] cfg);
    o_startup_config_port = cfg;
  endtask : set_config
  task automatic press_reset();
    o_hw_reset_in_n = 1'b0;
  endtask : press_reset
  task automatic let_go();
    o_hw_reset_in_n = 1'b1;
  endtask : let_go
endmodule : reset_partner

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hw_n;
  logic [15:0] cfg_port;
  post_reset_pkg::instr_strobes_t instr = '0;
  logic wdcon_we = 1'b0;
  logic [15:0] wdcon_wdata = 16'h0000;
  logic [15:0] gpio_wdata = 16'h0000;
  logic gpio_we = 1'b0;
  logic rst_out_n, int_rst, bus_act, ale_low, rdwr_high, rdy_en, cause, wd_en, dis_ok;
  logic [7:0] seg;
  logic [4:0] cs_n;
  logic [15:0] gpio_oe;
  logic [7:0] latch;
  post_reset_pkg::reset_regs_t regs;
  int n_mismatch = 0;
  int num_checks = 0;
  int n;

  always #4 clk = ~clk;

  reset_partner u_partner (.i_clk(clk), .i_system_reset_out_n(rst_out_n), .o_hw_reset_in_n(hw_n),
    .o_startup_config_port(cfg_port), .o_external_access_pin());

  post_reset_state_control u_dut (.i_clk(clk), .i_resetn(resetn), .i_ce(1'b1), .i_hw_reset_in_n(hw_n),
    .i_startup_config_port(cfg_port), .i_instr(instr), .i_wdcon_we(wdcon_we), .i_wdcon_wdata(wdcon_wdata),
    .i_gpio_dir_wdata(gpio_wdata), .i_gpio_dir_we(gpio_we), .o_system_reset_out_n(rst_out_n),
    .o_internal_reset(int_rst), .o_bus_active(bus_act), .o_latch_strobe_weak_low(ale_low),
    .o_rdwr_cs_weak_high(rdwr_high), .o_ready_enable(rdy_en), .o_segment_lines(seg),
    .o_chip_select_n(cs_n), .o_gpio_oe(gpio_oe), .o_startup_config_latch(latch),
    .o_watchdog_cause_flag(cause), .o_watchdog_enabled(wd_en), .o_disable_allowed(dis_ok), .o_regs(regs));

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic strobe(input post_reset_pkg::instr_strobes_t s);
    @(negedge clk) instr = s;
    @(negedge clk) instr = '0;
  endtask : strobe

  // counts samples while the internal reset is up, starting at the current one
  task automatic count_reset(output int cnt);
    cnt = 0;
    while (int_rst === 1'b1 && cnt < 5000) begin
      if (cnt == 2) begin
        check(16'({ale_low, rdwr_high, rst_out_n}), 16'h0006);
      end
      cnt++;
      @(negedge clk);
    end
    if (cnt >= 5000) begin
      n_mismatch++;
      close_out();
    end
  endtask : count_reset

  task automatic chk_run(input logic [15:0] cfg, input logic wd);
    logic [15:0] exp_sys;
    logic bus_on;
    exp_sys = 16'h0000;
    exp_sys[post_reset_pkg::SYSTEM_CONFIG_REG_HIGH_BYTE_ENABLE_DISABLE_BIT] = ~cfg[7];
    bus_on = (cfg[7:6] != 2'h0);
    check(regs.data_page_ptr_1, 16'h0001);
    check(regs.data_page_ptr_2, 16'h0002);
    check(regs.data_page_ptr_3, 16'h0003);
    check(regs.context_pointer, 16'hFC00);
    check(regs.stack_pointer, 16'hFC00);
    check(regs.stack_underflow_limit, 16'hFC00);
    check(regs.stack_overflow_limit, 16'hFA00);
    check(regs.watchdog_control_reg, wd ? 16'h0002 : 16'h0000);
    check(16'(cause), 16'(wd));
    check(regs.system_config_reg, exp_sys);
    check(regs.bus_config_reg_0, 16'h0600 | {8'h00, cfg[7:6], 6'h00});
    check(16'(bus_act), 16'(bus_on));
    check(16'(cs_n), bus_on ? 16'h001E : 16'h001F);
    check(16'(seg), 16'h0000);
    check(16'(rdy_en), 16'h0000);
    check(16'(latch), {8'h00, cfg[15:8]});
    check(16'({ale_low, rdwr_high}), 16'h0000);
    check(gpio_oe, 16'h0000);
    check(16'(rst_out_n), 16'h0000);
    check(16'(u_partner.periph_in_reset_ff), 16'h0001);
  endtask : chk_run

  task automatic wd_overflow();
    @(negedge clk) wdcon_wdata = 16'hFF00;
    wdcon_we = 1'b1;
    @(negedge clk) wdcon_we = 1'b0;
    strobe('{end_of_init: 1'b0, wd_service: 1'b1, wd_disable: 1'b0, sw_reset: 1'b0});
    n = 0;
    while (int_rst !== 1'b1 && n < 2000) begin
      n++;
      @(negedge clk);
    end
    if (n >= 2000) begin
      n_mismatch++;
      close_out();
    end
    check(16'(n >= 505 && n <= 520), 16'h0001);
    check(16'(rst_out_n), 16'h0000);
    count_reset(n);
    check(16'(n), 16'd516);
    chk_run(cfg_port, 1'b1);
  endtask : wd_overflow

  initial begin
    u_partner.set_config(16'h5AC0);
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    count_reset(n);
    chk_run(16'h5AC0, 1'b0);
    check(16'(dis_ok), 16'h0001);
    @(negedge clk) gpio_wdata = 16'hF0F1;
    gpio_we = 1'b1;
    @(negedge clk) gpio_we = 1'b0;
    check(gpio_oe, 16'hF0F1);
    strobe('{end_of_init: 1'b0, wd_service: 1'b0, wd_disable: 1'b1, sw_reset: 1'b0});
    check(16'(wd_en), 16'h0000);
    strobe('{end_of_init: 1'b1, wd_service: 1'b0, wd_disable: 1'b0, sw_reset: 1'b0});
    n = 0;
    while (rst_out_n !== 1'b1 && n < 2) begin
      n++;
      @(negedge clk);
    end
    check(16'(rst_out_n), 16'h0001);
    u_partner.set_config(16'h3A40);
    strobe('{end_of_init: 1'b0, wd_service: 1'b0, wd_disable: 1'b0, sw_reset: 1'b1});
    check(16'({rst_out_n, int_rst}), 16'h0001);
    count_reset(n);
    check(16'(n), 16'd516);
    chk_run(16'h3A40, 1'b0);
    check(16'(wd_en), 16'h0001);
    strobe('{end_of_init: 1'b1, wd_service: 1'b0, wd_disable: 1'b0, sw_reset: 1'b0});
    strobe('{end_of_init: 1'b0, wd_service: 1'b0, wd_disable: 1'b1, sw_reset: 1'b0});
    check(16'({wd_en, dis_ok}), 16'h0002);
    wd_overflow();
    u_partner.set_config(16'h6600);
    strobe('{end_of_init: 1'b1, wd_service: 1'b0, wd_disable: 1'b0, sw_reset: 1'b0});
    check(16'(rst_out_n), 16'h0001);
    @(negedge clk) u_partner.press_reset();
    #1 check(16'(rst_out_n), 16'h0000);
    repeat (700) @(negedge clk);
    check(16'(int_rst), 16'h0001);
    u_partner.let_go();
    count_reset(n);
    check(16'(n <= 6), 16'h0001);
    chk_run(16'h6600, 1'b0);
    wd_overflow();
    strobe('{end_of_init: 1'b0, wd_service: 1'b1, wd_disable: 1'b0, sw_reset: 1'b0});
    check(16'(cause), 16'h0000);
    close_out();
  end
endmodule : tb
